// ==== core/arc_address_resolver.sv ====
// Address resolver control: registers, key sequencer, events, interrupt
//
// Summary of operation
// - Writing 1 to start task launches a resolution pass over the key table.
// - Writing 1 to stop task aborts any pass in progress.
// - Done event is set when a pass finishes, whatever the outcome.
// - No-match event is set when no key resolves the address and the pass was not stopped.
// - Writing 1 to interrupt-enable-set bit 0 enables the done interrupt.
// - Writing 1 to the match bit of enable-set enables the match interrupt.
// - Writing 1 to an interrupt-enable-clear bit disables that interrupt.
// - Reading enable-set or enable-clear returns the current enable bits.
// - Match event on success, no-match when every key fails, neither on stop; keys tried from zero upward.
// - Stop at first matching key or after key count keys (clamped to 16), then done.
// - Event stays set until software writes 0 to it or 1 to its event-clear bit; may re-fire while set.
// - Interrupt is high while any event is set with its enable on.
`timescale 1ns/1ps

module arc_address_resolver
    import arc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Register port
    input  wire arc_bus_t    bus,
    output logic [31:0]      rdata,
    // Hash engine
    output arc_req_t         engine_req,
    output logic             engine_abort,
    input  wire arc_rsp_t    engine_rsp,
    // Interrupt
    output logic             irq
);

    arc_state_t          state_q;
    logic [3:0]          key_idx_q;
    logic [3:0]          status_q;
    logic [1:0]          enable_q;
    logic [4:0]          key_count_q;
    logic [31:0]         key_table_ptr_q;
    logic [31:0]         address_ptr_q;
    logic [31:0]         scratch_ptr_q;
    logic [EV_COUNT-1:0] event_q;
    logic [EV_COUNT-1:0] inten_q;
    logic [EV_COUNT-1:0] event_set;
    logic [EV_COUNT-1:0] event_clr;
    logic [31:0]         rdata_q;
    arc_req_t            req_q;
    logic                abort_q;
    logic                start_hit;
    logic                stop_hit;
    logic                launch;
    logic                last_key;
    logic [4:0]          key_count_eff;

    // Task strobes from register writes
    assign start_hit = bus.wr && bus.addr == OFS_START_TASK && bus.wdata[0];
    assign stop_hit  = bus.wr && bus.addr == OFS_STOP_TASK && bus.wdata[0];

    // Launch only from idle with the resolver switched on
    assign launch = start_hit && state_q == ARC_IDLE && enable_q == ENABLE_ON;

    // Counts above the table size are clamped; the table holds 16 keys
    assign key_count_eff = (key_count_q > KEY_COUNT_MAX) ? KEY_COUNT_MAX
                                                         : key_count_q;
    assign last_key = ({1'b0, key_idx_q} + 5'h01) >= key_count_eff;

    // Key sequencer
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= ARC_IDLE;
            key_idx_q <= 4'h0;
        end else begin
            case (state_q)
                ARC_IDLE: begin
                    if (launch) begin
                        key_idx_q <= 4'h0;
                        state_q   <= (key_count_eff == 5'h00) ? ARC_FINISH
                                                              : ARC_ISSUE;
                    end
                end
                ARC_ISSUE: begin
                    state_q <= stop_hit ? ARC_FINISH : ARC_WAIT;
                end
                ARC_WAIT: begin
                    if (stop_hit) begin
                        state_q <= ARC_FINISH;
                    end else if (engine_rsp.done) begin
                        if (engine_rsp.match || last_key) begin
                            state_q <= ARC_FINISH;
                        end else begin
                            key_idx_q <= key_idx_q + 4'h1;
                            state_q   <= ARC_ISSUE;
                        end
                    end
                end
                ARC_FINISH: begin
                    state_q <= ARC_IDLE;
                end
                default: begin
                    state_q <= ARC_IDLE;
                end
            endcase
        end
    end

    // Event sources; an abort still ends the pass, so it reports done
    always_comb begin
        event_set = '0;
        event_set[EV_DONE] = state_q == ARC_FINISH;
        event_set[EV_MATCH] = state_q == ARC_WAIT && !stop_hit
                              && engine_rsp.done && engine_rsp.match;
        event_set[EV_NO_MATCH] = (state_q == ARC_WAIT && !stop_hit
                                  && engine_rsp.done && !engine_rsp.match
                                  && last_key)
                                 || (launch && key_count_eff == 5'h00);
    end

    // Event clears: write 0 to an event register, or 1 to the clear register
    always_comb begin
        event_clr = '0;
        if (bus.wr) begin
            event_clr[EV_DONE] = (bus.addr == OFS_DONE_EVENT && !bus.wdata[0])
                || (bus.addr == OFS_EVENT_CLEAR && bus.wdata[EV_DONE]);
            event_clr[EV_MATCH] = (bus.addr == OFS_MATCH_EVENT
                && !bus.wdata[0])
                || (bus.addr == OFS_EVENT_CLEAR && bus.wdata[EV_MATCH]);
            event_clr[EV_NO_MATCH] = (bus.addr == OFS_NO_MATCH_EVENT
                && !bus.wdata[0])
                || (bus.addr == OFS_EVENT_CLEAR && bus.wdata[EV_NO_MATCH]);
        end
    end

    // Sticky events; a set in the clearing cycle wins so nothing is lost
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            event_q <= '0;
        end else begin
            event_q <= event_set | (event_q & ~event_clr);
        end
    end

    // Interrupt enables: set and clear registers share one state
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            inten_q <= '0;
        end else if (bus.wr && bus.addr == OFS_INT_ENABLE_SET) begin
            inten_q <= inten_q | bus.wdata[EV_COUNT-1:0];
        end else if (bus.wr && bus.addr == OFS_INT_ENABLE_CLR) begin
            inten_q <= inten_q & ~bus.wdata[EV_COUNT-1:0];
        end
    end

    // Level interrupt
    assign irq = |(event_q & inten_q);

    // Configuration registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            enable_q        <= ENABLE_RESET;
            key_count_q     <= KEY_COUNT_RESET;
            key_table_ptr_q <= PTR_RESET;
            address_ptr_q   <= PTR_RESET;
            scratch_ptr_q   <= PTR_RESET;
        end else if (bus.wr) begin
            case (bus.addr)
                OFS_ENABLE:        enable_q        <= bus.wdata[1:0];
                OFS_KEY_COUNT:     key_count_q     <= bus.wdata[4:0];
                OFS_KEY_TABLE_PTR: key_table_ptr_q <= bus.wdata;
                OFS_ADDRESS_PTR:   address_ptr_q   <= bus.wdata;
                OFS_SCRATCH_PTR:   scratch_ptr_q   <= bus.wdata;
                default: begin
                end
            endcase
        end
    end

    // Index of the key that matched last
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= STATUS_RESET;
        end else if (event_set[EV_MATCH]) begin
            status_q <= key_idx_q;
        end
    end

    // Engine request, one cycle per key; pointers copied from their registers every cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            req_q   <= '0;
            abort_q <= 1'b0;
        end else begin
            req_q.valid       <= state_q == ARC_ISSUE && !stop_hit;
            req_q.key_index   <= key_idx_q;
            req_q.key_addr    <= key_table_ptr_q
                                 + {24'h00_0000, key_idx_q, 4'h0};
            req_q.addr_ptr    <= address_ptr_q;
            req_q.scratch_ptr <= scratch_ptr_q;
            abort_q <= stop_hit && state_q != ARC_IDLE;
        end
    end

    assign engine_req   = req_q;
    assign engine_abort = abort_q;

    // Read data, valid only in the cycle after the read strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= 32'h0000_0000;
            if (bus.rd) begin
                case (bus.addr)
                    OFS_DONE_EVENT:     rdata_q[0] <= event_q[EV_DONE];
                    OFS_MATCH_EVENT:    rdata_q[0] <= event_q[EV_MATCH];
                    OFS_NO_MATCH_EVENT: rdata_q[0] <= event_q[EV_NO_MATCH];
                    OFS_INT_ENABLE_SET,
                    OFS_INT_ENABLE_CLR: rdata_q[EV_COUNT-1:0] <= inten_q;
                    OFS_STATUS:         rdata_q[3:0] <= status_q;
                    OFS_EVENT_SUMMARY:  rdata_q[EV_COUNT-1:0] <= event_q;
                    OFS_ENABLE:         rdata_q[1:0] <= enable_q;
                    OFS_KEY_COUNT:      rdata_q[4:0] <= key_count_q;
                    OFS_KEY_TABLE_PTR:  rdata_q <= key_table_ptr_q;
                    OFS_ADDRESS_PTR:    rdata_q <= address_ptr_q;
                    OFS_SCRATCH_PTR:    rdata_q <= scratch_ptr_q;
                    default: begin
                    end
                endcase
            end
        end
    end

    assign rdata = rdata_q;

    // Checks; each property names its own clock and reset

    AST_START_LAUNCH: assert property (
        @(posedge clock) disable iff (!reset_n)
        launch && key_count_eff != 5'h00
        |=> ##1 engine_req.valid && engine_req.key_index == 4'h0)
        else $error("start did not issue key zero");

    AST_STOP_ABORT: assert property (
        @(posedge clock) disable iff (!reset_n)
        stop_hit && (state_q == ARC_ISSUE || state_q == ARC_WAIT)
        |=> engine_abort && state_q == ARC_FINISH ##1 state_q == ARC_IDLE)
        else $error("stop did not abort the pass");

    AST_DONE_SET: assert property (
        @(posedge clock) disable iff (!reset_n)
        state_q == ARC_FINISH |=> event_q[EV_DONE])
        else $error("done event missing after finish");

    AST_NO_MATCH: assert property (
        @(posedge clock) disable iff (!reset_n)
        state_q == ARC_WAIT && !stop_hit && engine_rsp.done
        && !engine_rsp.match && last_key
        |=> event_q[EV_NO_MATCH] && state_q == ARC_FINISH
        ##1 event_q[EV_DONE])
        else $error("no-match not reported after last key");

    AST_MATCH: assert property (
        @(posedge clock) disable iff (!reset_n)
        state_q == ARC_WAIT && !stop_hit && engine_rsp.done && engine_rsp.match
        |=> event_q[EV_MATCH] && status_q == $past(key_idx_q)
        && state_q == ARC_FINISH)
        else $error("match not reported with its key index");

    AST_NEXT_KEY: assert property (
        @(posedge clock) disable iff (!reset_n)
        state_q == ARC_WAIT && !stop_hit && engine_rsp.done
        && !engine_rsp.match && !last_key
        |=> state_q == ARC_ISSUE && key_idx_q == $past(key_idx_q) + 4'h1)
        else $error("sequencer did not advance to next key");

    AST_INT_SET: assert property (
        @(posedge clock) disable iff (!reset_n)
        bus.wr && bus.addr == OFS_INT_ENABLE_SET && bus.wdata[EV_DONE]
        |=> inten_q[EV_DONE])
        else $error("enable-set did not enable done");

    AST_INT_CLR: assert property (
        @(posedge clock) disable iff (!reset_n)
        bus.wr && bus.addr == OFS_INT_ENABLE_CLR && bus.wdata[EV_MATCH]
        |=> !inten_q[EV_MATCH])
        else $error("enable-clear did not disable match");

    AST_WRITE_ZERO: assert property (
        @(posedge clock) disable iff (!reset_n)
        bus.wr && (bus.addr == OFS_INT_ENABLE_SET
        || bus.addr == OFS_INT_ENABLE_CLR) && !bus.wdata[EV_NO_MATCH]
        |=> $stable(inten_q[EV_NO_MATCH]))
        else $error("writing zero changed an enable bit");

    AST_EN_READ: assert property (
        @(posedge clock) disable iff (!reset_n)
        bus.rd && (bus.addr == OFS_INT_ENABLE_SET
        || bus.addr == OFS_INT_ENABLE_CLR)
        |=> rdata == {29'h0, $past(inten_q)})
        else $error("enable readback wrong");

    AST_EVENT_HOLD: assert property (
        @(posedge clock) disable iff (!reset_n)
        event_q[EV_DONE] && !event_clr[EV_DONE] |=> event_q[EV_DONE])
        else $error("done event dropped without a clear");

    AST_IRQ: assert property (
        @(posedge clock) disable iff (!reset_n)
        (event_q[EV_MATCH] && inten_q[EV_MATCH])
        || (event_q[EV_NO_MATCH] && inten_q[EV_NO_MATCH]) |-> irq)
        else $error("interrupt low with enabled event set");

    // Corner cases: empty table, refused start, idle engine, masking

    AST_EMPTY_TABLE: assert property (
        @(posedge clock) disable iff (!reset_n)
        launch && key_count_eff == 5'h00
        |=> event_q[EV_NO_MATCH] && state_q == ARC_FINISH
        ##1 event_q[EV_DONE] && state_q == ARC_IDLE)
        else $error("empty table did not end with no-match");

    AST_START_REFUSED: assert property (
        @(posedge clock) disable iff (!reset_n)
        start_hit && state_q == ARC_IDLE && enable_q != ENABLE_ON
        |=> state_q == ARC_IDLE)
        else $error("start accepted while the resolver was off");

    AST_IDLE_QUIET: assert property (
        @(posedge clock) disable iff (!reset_n)
        state_q == ARC_IDLE |=> !engine_req.valid)
        else $error("key request issued without a start");

    AST_ONE_REQUEST: assert property (
        @(posedge clock) disable iff (!reset_n)
        engine_req.valid |=> !engine_req.valid)
        else $error("key request held for more than one cycle");

    AST_ABORT_CAUSE: assert property (
        @(posedge clock) disable iff (!reset_n)
        engine_abort |-> $past(stop_hit))
        else $error("abort raised without a stop task");

    AST_MASK_ALL: assert property (
        @(posedge clock) disable iff (!reset_n)
        bus.wr && bus.addr == OFS_INT_ENABLE_CLR
        && bus.wdata[EV_COUNT-1:0] == 3'h7
        |=> !irq)
        else $error("interrupt high after every enable was cleared");

endmodule : arc_address_resolver

// ==== core/arc_pkg.sv ====
// Package: register map, field layout and carriers of the address resolver
package arc_pkg;

    // Register byte offsets
    localparam logic [11:0] OFS_START_TASK      = 12'h000;
    localparam logic [11:0] OFS_STOP_TASK       = 12'h008;
    localparam logic [11:0] OFS_DONE_EVENT      = 12'h100;
    localparam logic [11:0] OFS_MATCH_EVENT     = 12'h104;
    localparam logic [11:0] OFS_NO_MATCH_EVENT  = 12'h108;
    localparam logic [11:0] OFS_INT_ENABLE_SET  = 12'h304;
    localparam logic [11:0] OFS_INT_ENABLE_CLR  = 12'h308;
    localparam logic [11:0] OFS_STATUS          = 12'h400;
    localparam logic [11:0] OFS_EVENT_SUMMARY   = 12'h410;
    localparam logic [11:0] OFS_EVENT_CLEAR     = 12'h414;
    localparam logic [11:0] OFS_ENABLE          = 12'h500;
    localparam logic [11:0] OFS_KEY_COUNT       = 12'h504;
    localparam logic [11:0] OFS_KEY_TABLE_PTR   = 12'h508;
    localparam logic [11:0] OFS_ADDRESS_PTR     = 12'h510;
    localparam logic [11:0] OFS_SCRATCH_PTR     = 12'h514;

    // Event bit positions, shared by event-clear, summary and enable registers
    localparam int EV_DONE     = 0;
    localparam int EV_MATCH    = 1;
    localparam int EV_NO_MATCH = 2;
    localparam int EV_COUNT    = 3;

    // Field values and reset values
    localparam logic [1:0]  ENABLE_ON        = 2'h3;
    localparam logic [1:0]  ENABLE_RESET     = 2'h0;
    localparam logic [4:0]  KEY_COUNT_RESET  = 5'h01;
    localparam logic [4:0]  KEY_COUNT_MAX    = 5'h10;
    localparam logic [3:0]  STATUS_RESET     = 4'h0;
    localparam logic [31:0] PTR_RESET        = 32'h0000_0000;
    localparam logic [31:0] KEY_STRIDE_BYTES = 32'h0000_0010;

    // Processor-side register port
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } arc_bus_t;

    // Per-key request to the hash engine
    typedef struct packed {
        logic        valid;
        logic [3:0]  key_index;
        logic [31:0] key_addr;
        logic [31:0] addr_ptr;
        logic [31:0] scratch_ptr;
    } arc_req_t;

    // Hash engine answer for one key
    typedef struct packed {
        logic done;
        logic match;
    } arc_rsp_t;

    // Sequencer states, Gray along idle-issue-wait-finish
    typedef enum logic [1:0] {
        ARC_IDLE   = 2'b00,
        ARC_ISSUE  = 2'b01,
        ARC_WAIT   = 2'b11,
        ARC_FINISH = 2'b10
    } arc_state_t;

endpackage : arc_pkg

// ==== verif/arc_address_resolver_tb_top.sv ====
// Self-checking bench for the address resolver control block
`timescale 1ns/1ps

module arc_address_resolver_tb_top
    import arc_pkg::*;
;
    typedef struct packed {
        logic [11:0] wa;
        logic [31:0] wd;
        logic [11:0] ra;
        logic [31:0] exp;
    } arc_tb_row_t;

    logic        clock;
    logic        reset_n;
    arc_bus_t    bus;
    logic [31:0] rdata;
    arc_req_t    engine_req;
    logic        engine_abort;
    arc_rsp_t    engine_rsp;
    logic        irq;
    logic [4:0]  match_index;
    logic [3:0]  delay;
    int          fails;
    int          n_compared;
    int          n_req;
    int          n_abort;
    int          cycles;
    logic [31:0] key_base;

    // Write, then read back; enable rows build on each other
    arc_tb_row_t rows [0:11] = '{
        '{12'h304, 32'h1, 12'h304, 32'h1},
        '{12'h304, 32'h2, 12'h308, 32'h3},
        '{12'h304, 32'h0, 12'h304, 32'h3},
        '{12'h308, 32'h1, 12'h304, 32'h2},
        '{12'h308, 32'h0, 12'h308, 32'h2},
        '{12'h304, 32'h4, 12'h304, 32'h6},
        '{12'h508, 32'h2000_0100, 12'h508, 32'h2000_0100},
        '{12'h510, 32'h2000_0200, 12'h510, 32'h2000_0200},
        '{12'h514, 32'h2000_0300, 12'h514, 32'h2000_0300},
        '{12'h504, 32'h3, 12'h504, 32'h3},
        '{12'h500, 32'h3, 12'h500, 32'h3},
        '{12'h700, 32'hffff_ffff, 12'h700, 32'h0}
    };

    arc_address_resolver arc_address_resolver_inst (
        .clock        (clock),
        .reset_n      (reset_n),
        .bus          (bus),
        .rdata        (rdata),
        .engine_req   (engine_req),
        .engine_abort (engine_abort),
        .engine_rsp   (engine_rsp),
        .irq          (irq)
    );

    arc_engine_model arc_engine_model_inst (
        .clock       (clock),
        .reset_n     (reset_n),
        .req         (engine_req),
        .abort       (engine_abort),
        .rsp         (engine_rsp),
        .match_index (match_index),
        .delay       (delay)
    );

    // Clock at 100 ns period
    always #50 clock = ~clock;

    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : check

    task automatic stop_test();
        $display("Counts: %0d compared, %0d failed", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge clock);
        bus.wr    <= 1'b0;
    endtask : bus_write

    // Read data stand only in the cycle after the strobe
    task automatic bus_read(input logic [11:0] a, input logic [31:0] e,
                            input string n);
        @(posedge clock);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clock);
        bus.rd   <= 1'b0;
        @(negedge clock);
        check(n, e, rdata);
    endtask : bus_read

    task automatic start_pass(input logic [4:0] m);
        match_index <= m;
        n_req = 0;
        bus_write(OFS_START_TASK, 32'h1);
    endtask : start_pass

    // Bounded wait, sampled mid-cycle so register updates have landed
    task automatic wait_irq();
        for (int i = 0; i < 300 && irq !== 1'b1; i++) begin
            @(negedge clock);
        end
        check("irq raised", 32'h1, {31'h0, irq});
    endtask : wait_irq

    task automatic check_irq(input logic e);
        @(negedge clock);
        check("irq level", {31'h0, e}, {31'h0, irq});
    endtask : check_irq

    task automatic clear_events();
        bus_write(OFS_DONE_EVENT, 32'h0);
        bus_write(OFS_MATCH_EVENT, 32'h0);
        bus_write(OFS_NO_MATCH_EVENT, 32'h0);
    endtask : clear_events

    // Requests walk the key table upward from key zero; cycle ceiling
    always @(posedge clock) begin
        if (reset_n === 1'b1 && engine_req.valid === 1'b1) begin
            check("key index", 32'(n_req), 32'(engine_req.key_index));
            check("key addr", key_base + 32'(n_req) * 32'h10,
                  engine_req.key_addr);
            check("address ptr", 32'h2000_0200, engine_req.addr_ptr);
            check("scratch ptr", 32'h2000_0300,
                  engine_req.scratch_ptr);
            n_req++;
        end
        if (engine_abort === 1'b1) begin
            n_abort++;
        end
        cycles++;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end

    initial begin
        clock = 1'b0;
        reset_n = 1'b0;
        bus = '0;
        match_index = 5'h1f;
        delay = 4'h2;
        key_base = 32'h2000_0100;
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            bus_write(rows[i].wa, rows[i].wd);
            bus_read(rows[i].ra, rows[i].exp, "register row");
        end
        $display("Test register rows done");
        // Only done may interrupt, so irq marks the end of a pass
        bus_write(OFS_INT_ENABLE_CLR, 32'h7);
        bus_write(OFS_INT_ENABLE_SET, 32'h1);
        start_pass(5'h01);
        wait_irq();
        bus_read(OFS_MATCH_EVENT, 32'h1, "match event");
        bus_read(OFS_NO_MATCH_EVENT, 32'h0, "no-match event");
        bus_read(OFS_STATUS, 32'h1, "status");
        bus_write(OFS_INT_ENABLE_CLR, 32'h1);
        bus_write(OFS_INT_ENABLE_SET, 32'h2);
        check_irq(1'b1);
        bus_write(OFS_INT_ENABLE_CLR, 32'h2);
        check_irq(1'b0);
        bus_write(OFS_INT_ENABLE_SET, 32'h1);
        check("keys tried", 32'h2, 32'(n_req));
        bus_write(OFS_DONE_EVENT, 32'h1);
        bus_read(OFS_DONE_EVENT, 32'h1, "done held");
        clear_events();
        check_irq(1'b0);
        $display("Test match pass done");
        start_pass(5'h1f);
        wait_irq();
        bus_read(OFS_NO_MATCH_EVENT, 32'h1, "no-match event");
        bus_read(OFS_MATCH_EVENT, 32'h0, "match event");
        check("keys tried", 32'h3, 32'(n_req));
        bus_read(OFS_EVENT_SUMMARY, 32'h5, "event summary");
        bus_write(OFS_INT_ENABLE_CLR, 32'h1);
        check_irq(1'b0);
        bus_write(OFS_INT_ENABLE_SET, 32'h4);
        check_irq(1'b1);
        bus_write(OFS_INT_ENABLE_CLR, 32'h4);
        bus_write(OFS_INT_ENABLE_SET, 32'h1);
        check_irq(1'b1);
        $display("Test no-match and masking done");
        bus_write(OFS_EVENT_CLEAR, 32'h7);
        bus_read(OFS_EVENT_SUMMARY, 32'h0, "summary cleared");
        bus_write(OFS_KEY_COUNT, 32'h0);
        start_pass(5'h00);
        wait_irq();
        bus_read(OFS_NO_MATCH_EVENT, 32'h1, "empty table");
        check("keys tried", 32'h0, 32'(n_req));
        bus_write(OFS_KEY_COUNT, 32'h3);
        $display("Test empty table done");
        // Slow engine so the stop lands mid-key; key zero would match
        clear_events();
        delay <= 4'hf;
        n_abort = 0;
        start_pass(5'h00);
        for (int i = 0; i < 20 && n_req == 0; i++) begin
            @(negedge clock);
        end
        bus_write(OFS_STOP_TASK, 32'h1);
        wait_irq();
        check("aborts", 32'h1, 32'(n_abort));
        bus_read(OFS_MATCH_EVENT, 32'h0, "match after stop");
        bus_read(OFS_NO_MATCH_EVENT, 32'h0, "no-match after stop");
        $display("Test stop done");
        clear_events();
        bus_write(OFS_ENABLE, 32'h0);
        start_pass(5'h00);
        repeat (10) @(negedge clock);
        check("keys when off", 32'h0, 32'(n_req));
        bus_read(OFS_DONE_EVENT, 32'h0, "done when off");
        $display("Test disabled start done");
        @(posedge clock);
        reset_n <= 1'b0;
        check_irq(1'b0);
        @(posedge clock);
        reset_n <= 1'b1;
        bus_read(OFS_INT_ENABLE_SET, 32'h0, "enable reset");
        bus_read(OFS_KEY_COUNT, 32'h1, "key count reset");
        bus_read(OFS_ENABLE, 32'h0, "enable reset");
        bus_read(OFS_KEY_TABLE_PTR, 32'h0, "pointer reset");
        bus_read(OFS_STATUS, 32'h0, "status reset");
        $display("Test reset done");
        stop_test();
    end
endmodule : arc_address_resolver_tb_top

// ==== verif/arc_engine_model.sv ====
// Behavioural hash engine answering one key request at a time
`timescale 1ns/1ps

module arc_engine_model
    import arc_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // Resolver side
    input  wire arc_req_t   req,
    input  wire logic       abort,
    output arc_rsp_t        rsp,
    // Scenario controls
    input  wire logic [4:0] match_index,
    input  wire logic [3:0] delay
);
    logic       busy_q;
    logic [3:0] cnt_q;
    logic [3:0] idx_q;
    logic       toggle_q;

    // Match is garbage outside done, so a design that samples it late fails
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy_q   <= 1'b0;
            cnt_q    <= 4'h0;
            idx_q    <= 4'h0;
            toggle_q <= 1'b0;
            rsp      <= '0;
        end else begin
            toggle_q  <= ~toggle_q;
            rsp.done  <= 1'b0;
            rsp.match <= toggle_q;
            if (abort) begin
                busy_q <= 1'b0;
            end else if (req.valid) begin
                busy_q <= 1'b1;
                cnt_q  <= delay;
                idx_q  <= req.key_index;
            end else if (busy_q && cnt_q == 4'h0) begin
                busy_q    <= 1'b0;
                rsp.done  <= 1'b1;
                rsp.match <= ({1'b0, idx_q} == match_index);
            end else if (busy_q) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule : arc_engine_model
